// *** pkg/sst_pkg.sv ***
// Package with constants and types of the supervisor timer.
package sst_pkg;
  // Register offsets.
  localparam logic [7:0] CTL2_OFS  = 8'hcc;
  localparam logic [7:0] CTLR_OFS  = 8'hcd;
  localparam logic [7:0] COUNT_OFS = 8'hce;
  // Field positions.
  localparam int REN_BIT = 0;
  localparam int UDF_BIT = 3;
  // Values after reset and presets.
  localparam logic [7:0] PRESET_VAL = 8'hff;
  localparam logic [7:0] ZERO_VAL   = 8'h00;
  // Oscillator cycles per instruction cycle.
  localparam int TC_DIV = 10;
  // Instruction cycles of crystal start-up hold.
  localparam int START_TC = 256;
  // Bus request carried as one group.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } sst_bus_req_type;
  // Timer states.
  typedef enum logic [1:0] {
    SST_IDLE,
    SST_RUN,
    SST_START
  } sst_state_type;
endpackage : sst_pkg

// *** hdl/sst_tc_gen.sv ***
// Instruction-cycle tick generator dividing the oscillator clock.
`timescale 1ns/100ps
module sst_tc_gen #(
  parameter int DIV = sst_pkg::TC_DIV
) (
  input  wire logic clk,
  input  wire logic rst_n,
  output logic      tc_tick
);
  logic [7:0] div_r;
  logic [7:0] div_nxt;

  // Counts oscillator cycles and wraps once per instruction cycle.
  always_comb begin
    if (div_r == 8'(DIV - 1)) begin
      div_nxt = 8'h00;
    end else begin
      div_nxt = div_r + 8'h01;
    end
  end

  // Registers the divider count.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_r <= 8'h00;
    end else begin
      div_r <= div_nxt;
    end
  end

  // One-cycle tick at the end of each instruction cycle.
  assign tc_tick = (div_r == 8'(DIV - 1));
endmodule : sst_tc_gen

// *** hdl/sst_timer.sv ***
// Supervisor timer with prescaler, down counter and control bits.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/100ps
module sst_timer (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  sst_pkg::sst_bus_req_type      bus_req,
  output logic [7:0]                    bus_rdata,
  input  wire logic                     brownout_reset,
  input  wire logic                     ext_reset_n,
  input  wire logic                     halt_entry,
  input  wire logic                     wake_crystal,
  output logic                          supervisor_reset,
  output logic                          clock_hold
);
  logic [1:0]             s1_r, s2_r, s3_r, lvl_r;
  logic [1:0]             lvl_nxt;
  logic                   tc_tick;
  logic                   hard_rst;
  logic [7:0]             pre_r, pre_nxt;
  logic [7:0]             cnt_r, cnt_nxt;
  sst_pkg::sst_state_type st_r, st_nxt;
  logic                   ren_r, ren_nxt;
  logic                   once_r, once_nxt;
  logic                   udf_r, udf_nxt;
  logic                   run_r, run_nxt;
  logic                   srst_r, srst_nxt;
  logic [7:0]             rd_r, rd_nxt;
  logic                   ld_cnt;
  logic                   wr_ctl;
  logic                   uf;
  logic [1:0]             pin_raw;
  logic [11:0]            hold_cnt_r, hold_cnt_nxt;

  // Instruction-cycle tick from the oscillator clock.
  sst_tc_gen #(
    .DIV (sst_pkg::TC_DIV)
  ) u_tc (
    .clk     (clk),
    .rst_n   (rst_n),
    .tc_tick (tc_tick)
  );

  // Reset pins as asserted-high levels: bit 1 external, bit 0 brown-out.
  assign pin_raw = {~ext_reset_n, brownout_reset};

  // Each pin level is accepted only once the second and third stages agree.
  generate
    for (genvar i = 0; i < 2; i++) begin : g_sync
      always_comb begin
        if (s2_r[i] == s3_r[i]) begin
          lvl_nxt[i] = s3_r[i];
        end else begin
          lvl_nxt[i] = lvl_r[i];
        end
      end
    end
  endgenerate

  // Registers the synchroniser chain.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_r  <= 2'h0;
      s2_r  <= 2'h0;
      s3_r  <= 2'h0;
      lvl_r <= 2'h0;
    end else begin
      s1_r  <= pin_raw;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  // Brown-out or external reset, both preset counts and clear state, flag and the enable; the tick divider keeps running.
  assign hard_rst = lvl_r[0] | lvl_r[1];

  // Bus strobes decoded to register actions.
  assign ld_cnt = bus_req.we && (bus_req.addr == sst_pkg::COUNT_OFS);
  assign wr_ctl = bus_req.we && (bus_req.addr == sst_pkg::CTLR_OFS);

  // Underflow is the counter step below zero while running.
  assign uf = (st_r == sst_pkg::SST_RUN) && tc_tick && (pre_r == sst_pkg::ZERO_VAL) &&
              (cnt_r == sst_pkg::ZERO_VAL);

  // Next state of prescaler, counter and mode.
  always_comb begin
    pre_nxt = pre_r;
    cnt_nxt = cnt_r;
    st_nxt  = st_r;
    if (hard_rst) begin
      pre_nxt = sst_pkg::PRESET_VAL;
      cnt_nxt = sst_pkg::PRESET_VAL;
      st_nxt  = sst_pkg::SST_IDLE;
    end else if (halt_entry) begin
      pre_nxt = sst_pkg::PRESET_VAL;
      cnt_nxt = sst_pkg::PRESET_VAL;
      st_nxt  = sst_pkg::SST_IDLE;
    end else if (wake_crystal) begin
      pre_nxt = sst_pkg::PRESET_VAL;
      cnt_nxt = sst_pkg::PRESET_VAL;
      st_nxt  = sst_pkg::SST_START;
    end else if (ld_cnt) begin
      pre_nxt = sst_pkg::PRESET_VAL;
      cnt_nxt = bus_req.wdata;
      st_nxt  = sst_pkg::SST_RUN;
    end else if (tc_tick) begin
      case (st_r)
        sst_pkg::SST_RUN: begin
          pre_nxt = pre_r - 8'h01;
          if (pre_r == sst_pkg::ZERO_VAL) begin
            if (uf) begin
              pre_nxt = sst_pkg::PRESET_VAL;
              cnt_nxt = sst_pkg::PRESET_VAL;
              st_nxt  = sst_pkg::SST_IDLE;
            end else begin
              cnt_nxt = cnt_r - 8'h01;
            end
          end
        end
        sst_pkg::SST_START: begin
          pre_nxt = pre_r - 8'h01;
          if (pre_r == sst_pkg::ZERO_VAL) begin
            cnt_nxt = cnt_r - 8'h01;
            st_nxt  = sst_pkg::SST_IDLE;
          end
        end
        default: begin
          st_nxt = sst_pkg::SST_IDLE;
        end
      endcase
    end
  end

  // Next state of control and status bits.
  always_comb begin
    ren_nxt  = ren_r;
    once_nxt = once_r;
    udf_nxt  = udf_r;
    run_nxt  = run_r;
    srst_nxt = 1'b0;
    if (hard_rst) begin
      ren_nxt  = 1'b0;
      once_nxt = 1'b0;
      udf_nxt  = 1'b0;
      run_nxt  = 1'b0;
    end else begin
      if (wr_ctl && !once_r) begin
        ren_nxt  = bus_req.wdata[sst_pkg::REN_BIT];
        once_nxt = 1'b1;
      end
      if (ld_cnt) begin
        run_nxt = 1'b1;
      end
      if (halt_entry || ld_cnt) begin
        udf_nxt = 1'b0;
      end
      if (uf && !halt_entry && !wake_crystal) begin
        udf_nxt  = 1'b1;
        srst_nxt = ren_r;
        if (ren_r) begin
          run_nxt = 1'b0;
        end
      end
    end
  end

  // Read data for the cycle after a read strobe; unmapped reads return zero.
  always_comb begin
    rd_nxt = 8'h00;
    if (bus_req.re) begin
      if (bus_req.addr == sst_pkg::COUNT_OFS) begin
        rd_nxt = cnt_r;
      end else if (bus_req.addr == sst_pkg::CTLR_OFS) begin
        rd_nxt[sst_pkg::REN_BIT] = ren_r;
      end else if (bus_req.addr == sst_pkg::CTL2_OFS) begin
        rd_nxt[sst_pkg::UDF_BIT] = udf_r;
      end
    end
  end

  // Registers all timer state.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pre_r  <= sst_pkg::PRESET_VAL;
      cnt_r  <= sst_pkg::PRESET_VAL;
      st_r   <= sst_pkg::SST_IDLE;
      ren_r  <= 1'b0;
      once_r <= 1'b0;
      udf_r  <= 1'b0;
      run_r  <= 1'b0;
      srst_r <= 1'b0;
      rd_r   <= 8'h00;
    end else begin
      pre_r  <= pre_nxt;
      cnt_r  <= cnt_nxt;
      st_r   <= st_nxt;
      ren_r  <= ren_nxt;
      once_r <= once_nxt;
      udf_r  <= udf_nxt;
      run_r  <= run_nxt;
      srst_r <= srst_nxt;
      rd_r   <= rd_nxt;
    end
  end

  // Outputs.
  assign bus_rdata        = rd_r;
  assign supervisor_reset = srst_r;
  assign clock_hold       = (st_r == sst_pkg::SST_START);

  // Helper count of clock-hold cycles since the last wakeup, read only by assertions.
  always_comb begin
    hold_cnt_nxt = 12'h000;
    if (clock_hold && !wake_crystal) begin
      hold_cnt_nxt = hold_cnt_r + 12'h001;
    end
  end

  // Registers the helper count.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hold_cnt_r <= 12'h000;
    end else begin
      hold_cnt_r <= hold_cnt_nxt;
    end
  end

  // Tick period is exactly ten clocks.
  a_tick_period: assert property (@(posedge clk) disable iff (!rst_n)
    tc_tick |=> !tc_tick [*8] ##1 !tc_tick ##1 tc_tick)
    else $error("instruction tick period is not ten clocks");

  // A counter load presets the prescaler and starts running.
  a_load_starts: assert property (@(posedge clk) disable iff (!rst_n)
    ld_cnt && !hard_rst && !halt_entry && !wake_crystal |=>
    pre_r == 8'hff && cnt_r == $past(bus_req.wdata) && st_r == sst_pkg::SST_RUN && run_r)
    else $error("counter load did not preset and start");

  // Underflow with enable set pulses the reset and keeps the enable.
  a_uf_resets: assert property (@(posedge clk) disable iff (!rst_n)
    uf && ren_r && !hard_rst && !halt_entry && !wake_crystal |=>
    supervisor_reset && ren_r && udf_r && !run_r ##1 !supervisor_reset)
    else $error("enabled underflow did not reset once");

  // Underflow with enable clear only raises the flag and stops.
  a_uf_flag_only: assert property (@(posedge clk) disable iff (!rst_n)
    uf && !ren_r && !hard_rst && !halt_entry && !wake_crystal |=>
    !supervisor_reset && udf_r && st_r == sst_pkg::SST_IDLE && cnt_r == 8'hff)
    else $error("disabled underflow misbehaved");

  // A second control write leaves the enable alone.
  a_write_once: assert property (@(posedge clk) disable iff (!rst_n)
    wr_ctl && once_r && !hard_rst |=> ren_r == $past(ren_r))
    else $error("enable bit changed after its single write");

  // Halt entry presets both counts and clears the flag, run signal kept.
  a_halt_preset: assert property (@(posedge clk) disable iff (!rst_n)
    halt_entry && !hard_rst |=> pre_r == 8'hff && cnt_r == 8'hff && !udf_r &&
    run_r == $past(run_r))
    else $error("halt entry did not preset");

  // Hard reset clears enable, flag and run signal.
  a_hard_clear: assert property (@(posedge clk) disable iff (!rst_n)
    hard_rst |=> !ren_r && !udf_r && !run_r && cnt_r == 8'hff && pre_r == 8'hff)
    else $error("hard reset did not clear state");

  // Stopped timer keeps its count until reloaded.
  a_stop_holds: assert property (@(posedge clk) disable iff (!rst_n)
    st_r == sst_pkg::SST_IDLE && !ld_cnt && !hard_rst && !halt_entry && !wake_crystal |=>
    $stable(cnt_r) && $stable(pre_r))
    else $error("stopped timer changed");

  // Running prescaler steps down by one per tick when above zero.
  a_pre_step: assert property (@(posedge clk) disable iff (!rst_n)
    st_r == sst_pkg::SST_RUN && tc_tick && pre_r != 8'h00 && !ld_cnt && !hard_rst &&
    !halt_entry && !wake_crystal |=> pre_r == $past(pre_r) - 8'h01 && $stable(cnt_r))
    else $error("prescaler did not step");

  // Wakeup start-up raises the clock hold at once.
  a_wake_hold: assert property (@(posedge clk) disable iff (!rst_n)
    wake_crystal && !hard_rst && !halt_entry |=> clock_hold && pre_r == 8'hff)
    else $error("start-up hold not raised");

  // Start-up hold lasts the fixed count of instruction cycles.
  a_hold_length: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(clock_hold) && !$past(hard_rst) && !$past(halt_entry) && !$past(ld_cnt) |->
    int'(hold_cnt_r) >= (sst_pkg::START_TC - 1) * sst_pkg::TC_DIV + 1 &&
    int'(hold_cnt_r) <= sst_pkg::START_TC * sst_pkg::TC_DIV)
    else $error("start-up hold length is wrong");

  // Prescaler wrap from zero steps the counter down and reloads the prescaler.
  a_cnt_step: assert property (@(posedge clk) disable iff (!rst_n)
    st_r == sst_pkg::SST_RUN && tc_tick && pre_r == 8'h00 && cnt_r != 8'h00 && !ld_cnt && !hard_rst &&
    !halt_entry && !wake_crystal |=> cnt_r == $past(cnt_r) - 8'h01 && pre_r == 8'hff)
    else $error("counter did not step on prescaler wrap");

  // Between ticks a running timer holds both counts.
  a_run_between: assert property (@(posedge clk) disable iff (!rst_n)
    st_r == sst_pkg::SST_RUN && !tc_tick && !ld_cnt && !hard_rst && !halt_entry && !wake_crystal |=>
    $stable(pre_r) && $stable(cnt_r) && st_r == sst_pkg::SST_RUN)
    else $error("timer moved without a tick");

  // With the enable clear no device reset is produced.
  a_no_reset_off: assert property (@(posedge clk) disable iff (!rst_n)
    !ren_r |=> !supervisor_reset)
    else $error("reset produced while disabled");

  // The first control write takes the enable bit and closes the write.
  a_enable_first: assert property (@(posedge clk) disable iff (!rst_n)
    wr_ctl && !once_r && !hard_rst |=> ren_r == $past(bus_req.wdata[sst_pkg::REN_BIT]) && once_r)
    else $error("first control write not taken");

  // A counter read returns the count in the next cycle.
  a_read_count: assert property (@(posedge clk) disable iff (!rst_n)
    bus_req.re && bus_req.addr == sst_pkg::COUNT_OFS |=> bus_rdata == $past(cnt_r))
    else $error("counter read data wrong");

  // The flag moves only on hard reset, halt, load or underflow.
  a_flag_keep: assert property (@(posedge clk) disable iff (!rst_n)
    !hard_rst && !halt_entry && !ld_cnt && !uf |=> udf_r == $past(udf_r))
    else $error("underflow flag changed without cause");

  // A supervisor reset keeps the enable and leaves both counts preset.
  a_srst_keeps: assert property (@(posedge clk) disable iff (!rst_n)
    supervisor_reset && !$past(ld_cnt) |-> ren_r && pre_r == 8'hff && cnt_r == 8'hff)
    else $error("supervisor reset state wrong");
endmodule : sst_timer

// *** test/tb_sst_timer.sv ***
// Self-checking testbench of the supervisor timer with a small behavioural model.
`timescale 1ns/100ps
module tb_sst_timer;
  logic                     clk;
  logic                     rst_n;
  logic                     brownout_reset;
  logic                     ext_reset_n;
  logic                     halt_entry;
  logic                     wake_crystal;
  sst_pkg::sst_bus_req_type bus_req;
  logic [7:0]               bus_rdata;
  logic                     supervisor_reset;
  logic                     clock_hold;
  logic [7:0]               rd;
  logic [15:0]              lfsr_r;
  int                       failures;
  int                       num_checks;
  int                       sr_seen;
  int                       m_en;
  int                       m_once;
  localparam int UDF_T = 256 * sst_pkg::TC_DIV;
  localparam int HOLD_T = sst_pkg::START_TC * sst_pkg::TC_DIV;

  sst_timer u_dut (.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .brownout_reset(brownout_reset), .ext_reset_n(ext_reset_n), .halt_entry(halt_entry),
    .wake_crystal(wake_crystal), .supervisor_reset(supervisor_reset), .clock_hold(clock_hold));

  // Free-running oscillator clock.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Counts device reset pulses from underflow.
  always @(posedge clk) begin
    if (supervisor_reset === 1'b1) sr_seen++;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  task automatic chk_rd(input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t read data exp %h got %h", $time, exp, got);
    end
  endtask : chk_rd

  task automatic chk_pin(input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t bit exp %b got %b", $time, exp, got);
    end
  endtask : chk_pin

  task automatic chk_cnt(input int exp, input int got);
    num_checks++;
    if (got != exp) begin
      failures++;
      $display("MISMATCH %0t pulse count exp %0d got %0d", $time, exp, got);
    end
  endtask : chk_cnt

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge clk);
    bus_req <= '0;
    // The model keeps only the first control write after a reset.
    if (a == sst_pkg::CTLR_OFS && m_once == 0) begin
      m_en   = int'(d[sst_pkg::REN_BIT]);
      m_once = 1;
    end
  endtask : wr

  // Read one register; the data stands one cycle and then returns to zero.
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge clk);
    bus_req <= '0;
    #1 rd = bus_rdata;
    @(posedge clk);
    #1 chk_rd(8'h00, bus_rdata);
  endtask : rd_reg

  task automatic pulse(input int which);
    @(posedge clk);
    if (which == 0) halt_entry <= 1'b1;
    else wake_crystal <= 1'b1;
    @(posedge clk);
    halt_entry   <= 1'b0;
    wake_crystal <= 1'b0;
  endtask : pulse

  // Load n and check the flag just before and just after n+1 counts.
  task automatic load_udf(input logic [7:0] n);
    int s0;
    wr(sst_pkg::COUNT_OFS, n);
    s0 = sr_seen;
    repeat ((n + 1) * UDF_T - 40) @(posedge clk);
    rd_reg(sst_pkg::CTL2_OFS);
    chk_pin(1'b0, rd[sst_pkg::UDF_BIT]);
    repeat (70) @(posedge clk);
    rd_reg(sst_pkg::CTL2_OFS);
    chk_pin(1'b1, rd[sst_pkg::UDF_BIT]);
    rd_reg(sst_pkg::COUNT_OFS);
    chk_rd(sst_pkg::PRESET_VAL, rd);
    chk_cnt(m_en, sr_seen - s0);
  endtask : load_udf

  task automatic hard_reset(input int bo);
    @(posedge clk);
    if (bo == 1) brownout_reset <= 1'b1;
    else ext_reset_n <= 1'b0;
    repeat (6) @(posedge clk);
    brownout_reset <= 1'b0;
    ext_reset_n    <= 1'b1;
    repeat (8) @(posedge clk);
    m_en = 0;
    m_once = 0;
  endtask : hard_reset

  // Cuts a hang short.
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    $display("MISMATCH %0t watchdog expired", $time);
    finish_test();
  end

  // Main sequence of tests.
  initial begin
    failures = 0;
    num_checks = 0;
    sr_seen = 0;
    m_en = 0;
    m_once = 0;
    rst_n = 1'b0;
    brownout_reset = 1'b0;
    ext_reset_n = 1'b1;
    halt_entry = 1'b0;
    wake_crystal = 1'b0;
    bus_req = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(sst_pkg::COUNT_OFS);
    chk_rd(sst_pkg::PRESET_VAL, rd);
    rd_reg(sst_pkg::CTL2_OFS);
    chk_pin(1'b0, rd[sst_pkg::UDF_BIT]);
    rd_reg(8'h40);
    chk_rd(8'h00, rd);
    $display("test reset values done");
    lfsr_r = 16'h5868;
    for (int i = 0; i < 6; i++) begin
      lfsr_r = lfsr_next(lfsr_r);
      wr(sst_pkg::COUNT_OFS, lfsr_r[7:0]);
      wr(8'h40, lfsr_r[15:8]);
      wr(sst_pkg::CTL2_OFS, 8'hff);
      rd_reg(sst_pkg::COUNT_OFS);
      chk_rd(lfsr_r[7:0], rd);
      rd_reg(sst_pkg::CTL2_OFS);
      chk_pin(1'b0, rd[sst_pkg::UDF_BIT]);
    end
    $display("test load readback done");
    load_udf(8'h00);
    repeat (UDF_T + 100) @(posedge clk);
    rd_reg(sst_pkg::COUNT_OFS);
    chk_rd(sst_pkg::PRESET_VAL, rd);
    load_udf(8'h01);
    pulse(0);
    rd_reg(sst_pkg::CTL2_OFS);
    chk_pin(1'b0, rd[sst_pkg::UDF_BIT]);
    rd_reg(sst_pkg::COUNT_OFS);
    chk_rd(sst_pkg::PRESET_VAL, rd);
    $display("test timer mode and halt done");
    pulse(1);
    #1 chk_pin(1'b1, clock_hold);
    rd_reg(sst_pkg::COUNT_OFS);
    chk_rd(sst_pkg::PRESET_VAL, rd);
    repeat (HOLD_T - 50) @(posedge clk);
    #1 chk_pin(1'b1, clock_hold);
    repeat (80) @(posedge clk);
    #1 chk_pin(1'b0, clock_hold);
    rd_reg(sst_pkg::COUNT_OFS);
    chk_rd(sst_pkg::PRESET_VAL - 8'h01, rd);
    $display("test wakeup done");
    wr(sst_pkg::CTLR_OFS, 8'h01);
    wr(sst_pkg::CTLR_OFS, 8'h00);
    rd_reg(sst_pkg::CTLR_OFS);
    chk_pin(1'b1, rd[sst_pkg::REN_BIT]);
    load_udf(8'h00);
    load_udf(8'h00);
    $display("test supervisor mode done");
    for (int b = 0; b < 2; b++) begin
      hard_reset(b);
      rd_reg(sst_pkg::COUNT_OFS);
      chk_rd(sst_pkg::PRESET_VAL, rd);
      rd_reg(sst_pkg::CTL2_OFS);
      chk_pin(1'b0, rd[sst_pkg::UDF_BIT]);
      rd_reg(sst_pkg::CTLR_OFS);
      chk_pin(1'b0, rd[sst_pkg::REN_BIT]);
      load_udf(8'h00);
      wr(sst_pkg::CTLR_OFS, 8'h01);
      load_udf(8'h00);
    end
    $display("test hard resets done");
    finish_test();
  end
endmodule : tb_sst_timer
